// file: rtl/module_identity_capability.v
// Identification and capability register bank, read-only but for one control register, of a
// pluggable optical module, reached over an Avalon-MM slave port.
// Assumes a word-addressed master; one byte per register index.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "module_identity_capability_regs.vh"

module module_identity_capability #(
  parameter [15:0]  MIN_WAVELENGTH     = 16'h0000,
  parameter [15:0]  MAX_WAVELENGTH     = 16'h0000,
  parameter [15:0]  MAX_LANE_OPT_WIDTH = 16'h0000,
  parameter [3:0]   LASER_TECH         = 4'h0,
  parameter [3:0]   MODULATOR_TECH     = 4'h0,
  parameter [0:0]   WL_CONTROL         = 1'b0,
  parameter [0:0]   COOLED_TX          = 1'b0,
  parameter [0:0]   TUNABLE            = 1'b0,
  parameter [0:0]   RX_ATTENUATOR      = 1'b0,
  parameter [2:0]   DETECTOR_TYPE      = 3'h0,
  parameter [0:0]   DISP_COMPENSATION  = 1'b0,
  parameter [3:0]   POLARITY_CODING    = 4'h0,
  parameter [3:0]   SIGNAL_CODING      = 4'h0,
  parameter [7:0]   MAX_OUTPUT_POWER   = 8'h00,
  parameter [7:0]   MAX_INPUT_POWER    = 8'h00,
  parameter [7:0]   MAX_POWER_DRAW     = 8'h00,
  parameter [7:0]   MAX_LOW_POWER_DRAW = 8'h00,
  parameter [7:0]   MAX_CASE_TEMP      = `CASE_TEMP_UNDEFINED,
  parameter [7:0]   MIN_CASE_TEMP      = `CASE_TEMP_UNDEFINED,
  // Identity text and codes below are arbitrary neutral values.
  parameter [127:0] MAKER_NAME         = "EXAMPLE VENDOR  ",
  parameter [23:0]  MAKER_ORG_ID       = 24'h000000,
  parameter [127:0] MAKER_PART         = "EXAMPLE PART    ",
  parameter [127:0] MAKER_SERIAL       = 128'h0,
  parameter [63:0]  DATE_CODE          = 64'h0,
  parameter [15:0]  LOT_CODE           = 16'h0000,
  parameter [79:0]  EQUIPMENT_ID       = 80'h0,
  parameter [7:0]   HW_SPEC_REV        = 8'h00,
  parameter [7:0]   MGMT_SPEC_REV      = 8'h00,
  parameter [7:0]   HW_VERSION_MAJOR   = 8'h00,
  parameter [7:0]   HW_VERSION_MINOR   = 8'h00,
  parameter [7:0]   FW_VERSION_MAJOR   = 8'h00,
  parameter [7:0]   FW_VERSION_MINOR   = 8'h00,
  parameter [7:0]   DIAG_MONITOR_TYPE  = 8'h00,
  parameter [7:0]   DIAG_MODULE_CAP    = 8'h00,
  parameter [7:0]   DIAG_LANE_CAP      = 8'h00
) (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [15:0] address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [31:0] writedata_i,
  input  wire [3:0]  byteenable_i,
  output reg  [31:0] readdata_o,
  output reg         waitrequest_o,
  output reg  [1:0]  response_o
);

  // Slave handshake states.
  localparam [0:0] ST_IDLE   = 1'b0;
  localparam [0:0] ST_ANSWER = 1'b1;

  // Handshake state, error-response enable and refused-write count.
  reg [0:0] state;
  reg       err_enable;
  reg [7:0] ignored_writes;

  // Capability bytes assembled from their fields.
  wire [7:0] tech_one;
  wire [7:0] tech_two;
  wire [7:0] signal_code;

  // Laser type high nibble, modulator code low nibble.
  assign tech_one[`TECH1_LASER_MSB:`TECH1_LASER_LSB] = LASER_TECH;
  assign tech_one[`TECH1_MODULATOR_MSB:`TECH1_MODULATOR_LSB] =
    MODULATOR_TECH;

  // One flag per optical feature, plus the detector type code.
  assign tech_two[`TECH2_WL_CONTROL_BIT] = WL_CONTROL;
  assign tech_two[`TECH2_COOLED_BIT]     = COOLED_TX;
  assign tech_two[`TECH2_TUNABLE_BIT]    = TUNABLE;
  assign tech_two[`TECH2_RX_ATTEN_BIT]   = RX_ATTENUATOR;
  assign tech_two[`TECH2_DETECTOR_MSB:`TECH2_DETECTOR_LSB] = DETECTOR_TYPE;
  assign tech_two[`TECH2_DISP_COMP_BIT]  = DISP_COMPENSATION;

  // Zero in either field reads as undefined to the host.
  assign signal_code[`SIGCODE_POLARITY_MSB:`SIGCODE_POLARITY_LSB] =
    POLARITY_CODING;
  assign signal_code[`SIGCODE_CODING_MSB:`SIGCODE_CODING_LSB] =
    SIGNAL_CODING;

  // Reverses the bits of a byte for the organisation identifier.
  function [7:0] bit_reverse;
    input [7:0] b;
    integer     k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        bit_reverse[k] = b[7 - k];
      end
    end
  endfunction

  // True for every index that this bank answers.
  function is_mapped;
    input [15:0] idx;
    begin
      is_mapped = ((idx >= `IDX_MIN_WAVELENGTH) &&
                   (idx <= `IDX_DIAG_LANE_CAP)) ||
                  (idx == `IDX_BANK_CONTROL) ||
                  (idx == `IDX_BANK_STATUS);
    end
  endfunction

  // Organisation identifier, stored bit-reversed per byte.
  wire [23:0] org_id_stored;
  genvar      g;
  generate
    for (g = 0; g < `NB_ORG_ID; g = g + 1) begin : g_org
      assign org_id_stored[g*8 +: 8] =
        bit_reverse(MAKER_ORG_ID[g*8 +: 8]);
    end
  endgenerate

  // Multi-byte fields: first byte at the lowest index.
  wire [7:0] b_minwl;
  wire [7:0] b_maxwl;
  wire [7:0] b_width;
  wire [7:0] b_name;
  wire [7:0] b_org;
  wire [7:0] b_part;
  wire [7:0] b_serial;
  wire [7:0] b_date;
  wire [7:0] b_lot;
  wire [7:0] b_equip;
  wire [7:0] b_hwver;
  wire [7:0] b_fwver;
  wire [11:0] hits;

  // Lowest wavelength, high byte at the lower index.
  field_byte_pick #(.NBYTES(`NB_WORD16), .BASE(`IDX_MIN_WAVELENGTH))
  u_minwl (.index_i(address_i), .field_i(MIN_WAVELENGTH),
           .hit_o(hits[0]), .byte_o(b_minwl));

  // Highest wavelength, high byte at the lower index.
  field_byte_pick #(.NBYTES(`NB_WORD16), .BASE(`IDX_MAX_WAVELENGTH))
  u_maxwl (.index_i(address_i), .field_i(MAX_WAVELENGTH),
           .hit_o(hits[1]), .byte_o(b_maxwl));

  // Widest lane optical width, high byte first.
  field_byte_pick #(.NBYTES(`NB_WORD16), .BASE(`IDX_MAX_LANE_OPT_WIDTH))
  u_width (.index_i(address_i), .field_i(MAX_LANE_OPT_WIDTH),
           .hit_o(hits[2]), .byte_o(b_width));

  // Maker name text, first character at the base index.
  field_byte_pick #(.NBYTES(`NB_TEXT16), .BASE(`IDX_MAKER_NAME))
  u_name (.index_i(address_i), .field_i(MAKER_NAME),
          .hit_o(hits[3]), .byte_o(b_name));

  // Organisation identifier, bytes already bit-reversed.
  field_byte_pick #(.NBYTES(`NB_ORG_ID), .BASE(`IDX_MAKER_ORG_ID))
  u_org (.index_i(address_i), .field_i(org_id_stored),
         .hit_o(hits[4]), .byte_o(b_org));

  // Part number text, first character at the base index.
  field_byte_pick #(.NBYTES(`NB_TEXT16), .BASE(`IDX_MAKER_PART))
  u_part (.index_i(address_i), .field_i(MAKER_PART),
          .hit_o(hits[5]), .byte_o(b_part));

  // Serial number text, first character at the base index.
  field_byte_pick #(.NBYTES(`NB_TEXT16), .BASE(`IDX_MAKER_SERIAL))
  u_serial (.index_i(address_i), .field_i(MAKER_SERIAL),
            .hit_o(hits[6]), .byte_o(b_serial));

  // Date code text, eight characters.
  field_byte_pick #(.NBYTES(`NB_DATE_CODE), .BASE(`IDX_DATE_CODE))
  u_date (.index_i(address_i), .field_i(DATE_CODE),
          .hit_o(hits[7]), .byte_o(b_date));

  // Lot code text, two characters.
  field_byte_pick #(.NBYTES(`NB_LOT_CODE), .BASE(`IDX_LOT_CODE))
  u_lot (.index_i(address_i), .field_i(LOT_CODE),
         .hit_o(hits[8]), .byte_o(b_lot));

  // Equipment identifier text, ten characters.
  field_byte_pick #(.NBYTES(`NB_EQUIPMENT_ID), .BASE(`IDX_EQUIPMENT_ID))
  u_equip (.index_i(address_i), .field_i(EQUIPMENT_ID),
           .hit_o(hits[9]), .byte_o(b_equip));

  // Hardware version, major byte at the lower index.
  field_byte_pick #(.NBYTES(`NB_WORD16), .BASE(`IDX_MODULE_HW_VERSION))
  u_hwver (.index_i(address_i),
           .field_i({HW_VERSION_MAJOR, HW_VERSION_MINOR}),
           .hit_o(hits[10]), .byte_o(b_hwver));

  // Firmware version, major byte at the lower index.
  field_byte_pick #(.NBYTES(`NB_WORD16), .BASE(`IDX_MODULE_FW_VERSION))
  u_fwver (.index_i(address_i),
           .field_i({FW_VERSION_MAJOR, FW_VERSION_MINOR}),
           .hit_o(hits[11]), .byte_o(b_fwver));

  // Merged byte of the multi-byte fields; the hit flags gate it below.
  wire [7:0] multi_byte;
  assign multi_byte = b_minwl | b_maxwl | b_width | b_name | b_org |
                      b_part | b_serial | b_date | b_lot | b_equip |
                      b_hwver | b_fwver;

  // Read value of the addressed index, zero where nothing is mapped.
  reg [7:0] read_byte;
  always @* begin
    read_byte = `BYTE_ZERO;
    case (address_i)
      `IDX_DEVICE_TECH_ONE:    read_byte = tech_one;
      `IDX_DEVICE_TECH_TWO:    read_byte = tech_two;
      `IDX_SIGNAL_CODE:        read_byte = signal_code;
      `IDX_MAX_OUTPUT_POWER:   read_byte = MAX_OUTPUT_POWER;
      `IDX_MAX_INPUT_POWER:    read_byte = MAX_INPUT_POWER;
      `IDX_MAX_POWER_DRAW:     read_byte = MAX_POWER_DRAW;
      `IDX_MAX_LOW_POWER_DRAW: read_byte = MAX_LOW_POWER_DRAW;
      `IDX_MAX_CASE_TEMP:      read_byte = MAX_CASE_TEMP;
      `IDX_MIN_CASE_TEMP:      read_byte = MIN_CASE_TEMP;
      `IDX_HW_SPEC_REV:        read_byte = HW_SPEC_REV;
      `IDX_MGMT_SPEC_REV:      read_byte = MGMT_SPEC_REV;
      `IDX_DIAG_MONITOR_TYPE:  read_byte = DIAG_MONITOR_TYPE;
      `IDX_DIAG_MODULE_CAP:    read_byte = DIAG_MODULE_CAP;
      `IDX_DIAG_LANE_CAP:      read_byte = DIAG_LANE_CAP;
      `IDX_BANK_CONTROL: begin
        read_byte = `BYTE_ZERO;
        read_byte[`CTRL_ERR_ENABLE_BIT] = err_enable;
      end
      `IDX_BANK_STATUS:        read_byte = ignored_writes;
      default:                 read_byte = (|hits) ? multi_byte : `BYTE_ZERO;
    endcase
  end

  // A write to anything but the control register changes nothing but the refused-write count.
  wire ctrl_write;
  wire write_refused;
  wire access_error;
  assign ctrl_write    = write_i && (address_i == `IDX_BANK_CONTROL) &&
                         byteenable_i[0];
  assign write_refused = write_i && (address_i != `IDX_BANK_CONTROL);
  assign access_error  = !is_mapped(address_i) || write_refused;

  // Next values of the handshake and of the readable state.
  reg [0:0]  next_state;
  reg        next_wait;
  reg [31:0] next_readdata;
  reg [1:0]  next_response;
  reg        next_err_enable;
  reg [7:0]  next_ignored;

  // Each request is answered one cycle after it is first seen, then
  // the slave rests one cycle while the master releases it.
  always @* begin
    next_state      = state;
    next_wait       = `RST_WAIT;
    next_readdata   = readdata_o;
    next_response   = response_o;
    next_err_enable = err_enable;
    next_ignored    = ignored_writes;
    case (state)
      ST_IDLE: begin
        if (read_i || write_i) begin
          next_state    = ST_ANSWER;
          next_wait     = 1'b0;
          next_readdata = read_i ? {24'h000000, read_byte} : `RST_DATA;
          // The error response is only given once software enables it.
          next_response = (err_enable && access_error) ?
                          `RESP_SLVERR : `RESP_OKAY;
          if (ctrl_write) begin
            next_err_enable = writedata_i[`CTRL_ERR_ENABLE_BIT];
          end
          // Every refused write is counted; the count wraps at its top.
          if (write_refused) begin
            next_ignored = ignored_writes + 8'h01;
          end
        end
      end
      ST_ANSWER: begin
        // Rest one cycle so that a request still held is not taken twice.
        next_state = ST_IDLE;
        next_wait  = `RST_WAIT;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registered state; all outputs come from these flip-flops.
  always @(posedge clk_i) begin
    if (srst_i) begin
      state          <= ST_IDLE;
      waitrequest_o  <= `RST_WAIT;
      readdata_o     <= `RST_DATA;
      response_o     <= `RESP_OKAY;
      err_enable     <= `RST_CTRL;
      ignored_writes <= `RST_COUNT;
    end else begin
      state          <= next_state;
      waitrequest_o  <= next_wait;
      readdata_o     <= next_readdata;
      response_o     <= next_response;
      err_enable     <= next_err_enable;
      ignored_writes <= next_ignored;
    end
  end

endmodule // module_identity_capability

`default_nettype wire

// file: rtl/module_identity_capability_regs.vh
// Constants for the identification and capability register bank.
// Assumes it is included once per compilation unit by its bare name.
`ifndef MODULE_IDENTITY_CAPABILITY_REGS_VH
`define MODULE_IDENTITY_CAPABILITY_REGS_VH

// Register indices; the bus byte address is four times the index.
`define IDX_MIN_WAVELENGTH       16'h8012
`define IDX_MAX_WAVELENGTH       16'h8014
`define IDX_MAX_LANE_OPT_WIDTH   16'h8016
`define IDX_DEVICE_TECH_ONE      16'h8018
`define IDX_DEVICE_TECH_TWO      16'h8019
`define IDX_SIGNAL_CODE          16'h801A
`define IDX_MAX_OUTPUT_POWER     16'h801B
`define IDX_MAX_INPUT_POWER      16'h801C
`define IDX_MAX_POWER_DRAW       16'h801D
`define IDX_MAX_LOW_POWER_DRAW   16'h801E
`define IDX_MAX_CASE_TEMP        16'h801F
`define IDX_MIN_CASE_TEMP        16'h8020
`define IDX_MAKER_NAME           16'h8021
`define IDX_MAKER_ORG_ID         16'h8031
`define IDX_MAKER_PART           16'h8034
`define IDX_MAKER_SERIAL         16'h8044
`define IDX_DATE_CODE            16'h8054
`define IDX_LOT_CODE             16'h805C
`define IDX_EQUIPMENT_ID         16'h805E
`define IDX_HW_SPEC_REV          16'h8068
`define IDX_MGMT_SPEC_REV        16'h8069
`define IDX_MODULE_HW_VERSION    16'h806A
`define IDX_MODULE_FW_VERSION    16'h806C
`define IDX_DIAG_MONITOR_TYPE    16'h806E
`define IDX_DIAG_MODULE_CAP      16'h806F
`define IDX_DIAG_LANE_CAP        16'h8070
`define IDX_BANK_CONTROL         16'h8080
`define IDX_BANK_STATUS          16'h8081

// Field sizes in bytes.
`define NB_WORD16                2
`define NB_TEXT16                16
`define NB_ORG_ID                3
`define NB_DATE_CODE             8
`define NB_LOT_CODE              2
`define NB_EQUIPMENT_ID          10

// Field positions inside packed bytes.
`define TECH1_LASER_MSB          7
`define TECH1_LASER_LSB          4
`define TECH1_MODULATOR_MSB      3
`define TECH1_MODULATOR_LSB      0
`define TECH2_WL_CONTROL_BIT     7
`define TECH2_COOLED_BIT         6
`define TECH2_TUNABLE_BIT        5
`define TECH2_RX_ATTEN_BIT       4
`define TECH2_DETECTOR_MSB       3
`define TECH2_DETECTOR_LSB       1
`define TECH2_DISP_COMP_BIT      0
`define SIGCODE_POLARITY_MSB     7
`define SIGCODE_POLARITY_LSB     4
`define SIGCODE_CODING_MSB       3
`define SIGCODE_CODING_LSB       0
`define CTRL_ERR_ENABLE_BIT      0

// Reset values and fixed codes.
`define RST_WAIT                 1'b1
`define RST_CTRL                 1'b0
`define RST_COUNT                8'h00
`define RST_DATA                 32'h00000000
`define CASE_TEMP_UNDEFINED      8'h80
`define BYTE_ZERO                8'h00
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

// file: rtl/field_byte_pick.v
// Selects one byte of a multi-byte field from a register index.
// Assumes the first byte (lowest address) sits in the field's top bits.
`timescale 1ns/100ps
`default_nettype none

module field_byte_pick #(
  parameter        NBYTES = 2,
  parameter [15:0] BASE   = 16'h0000
) (
  input  wire [15:0]         index_i,
  input  wire [NBYTES*8-1:0] field_i,
  output reg                 hit_o,
  output reg  [7:0]          byte_o
);

  localparam [15:0] COUNT = NBYTES;
  localparam [15:0] LAST  = NBYTES - 1;

  reg [15:0]         rel;
  reg [15:0]         shamt;
  reg [NBYTES*8-1:0] shifted;

  // Index inside the field, then shift the wanted byte to the bottom.
  always @* begin
    rel     = index_i - BASE;
    hit_o   = (index_i >= BASE) && (rel < COUNT);
    shamt   = (LAST - rel) << 3;
    shifted = field_i >> shamt;
    byte_o  = hit_o ? shifted[7:0] : 8'h00;
  end

endmodule // field_byte_pick

`default_nettype wire

// file: dv/module_identity_capability_sva.sv
// Assertions on the bank's Avalon-MM slave port.
// Bound to the bank top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module module_identity_capability_sva (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [15:0] address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic [1:0]  response_o
);
  logic      err_en;
  wire [1:0] bad = err_en ? 2'h2 : 2'h0;
  wire       ans = !waitrequest_o;
  wire       req = read_i || write_i;
  wire       hole = address_i < 16'h8012 || address_i > 16'h8081 ||
                    (address_i > 16'h8070 && address_i < 16'h8080);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Error-response enable as left by answered control writes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_en <= 1'b0;
    end else if (ans && write_i && address_i == 16'h8080 &&
                 byteenable_i[0]) begin
      err_en <= writedata_i[0];
    end
  end
  a_take_answer:
  assert property (req && waitrequest_o && $past(waitrequest_o) &&
    !$past(srst_i) |=> ans) else $error("request not answered");
  a_answer_once:
  assert property (ans |=> waitrequest_o) else $error("answer too long");
  a_no_stray:
  assert property (!req |=> waitrequest_o) else $error("stray answer");
  a_hold_result:
  assert property (waitrequest_o && $past(waitrequest_o) && !$past(srst_i)
    |-> $stable(readdata_o) && $stable(response_o))
    else $error("result moved");
  a_write_nodata:
  assert property (ans && write_i |-> readdata_o == 32'h00000000)
    else $error("write returned data");
  a_read_byte:
  assert property (ans && read_i |-> readdata_o[31:8] == 24'h000000)
    else $error("upper read bytes set");
  a_field_okay:
  assert property (ans && read_i && !hole && address_i < 16'h8071
    |-> response_o == 2'h0) else $error("field read refused");
  a_hole_zero:
  assert property (ans && read_i && hole
    |-> readdata_o == 32'h00000000 && response_o == bad)
    else $error("unmapped read wrong");
  a_refused_resp:
  assert property (ans && write_i && address_i != 16'h8080
    |-> response_o == bad) else $error("refused write response");
  a_reset_idle:
  assert property ($fell(srst_i) |-> waitrequest_o &&
    readdata_o == 32'h00000000 && response_o == 2'h0)
    else $error("not idle after reset");
endmodule // module_identity_capability_sva
bind module_identity_capability module_identity_capability_sva i_sva (
  .clk_i(clk_i), .srst_i(srst_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
  .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .response_o(response_o));
`default_nettype wire

// file: dv/avalon_host_model.sv
// Host management controller: Avalon-MM master of single transfers.
// Assumes a slave that answers by dropping waitrequest.
`timescale 1ns/100ps
`default_nettype none
module avalon_host_model (
  input  wire logic        clk_i,
  input  wire logic        waitrequest_i,
  output var  logic [15:0] address_o,
  output var  logic        read_o,
  output var  logic        write_o,
  output var  logic [31:0] writedata_o,
  output var  logic [3:0]  byteenable_o
);
  bit held;
  // Idle master at time zero.
  initial begin
    held = 1'b0;
    address_o = 16'h0000;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h00000000;
    byteenable_o = 4'h0;
  end
  // Request stands until waitrequest is sampled low; keep chains the next
  // transfer onto the answer edge so back-to-back traffic is exercised.
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [31:0] d, input logic [3:0] be,
                        input bit keep);
    if (!held) begin
      @(posedge clk_i);
    end
    address_o <= a;
    writedata_o <= d;
    byteenable_o <= be;
    read_o <= !wr;
    write_o <= wr;
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    held = keep;
    if (!keep) begin
      read_o <= 1'b0;
      write_o <= 1'b0;
      writedata_o <= ~d;
    end
  endtask
endmodule // avalon_host_model
`default_nettype wire

// file: dv/tb_module_identity_capability.sv
// Self-checking bench for the identification register bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_module_identity_capability;
  localparam logic [23:0] ORG = 24'h1A2B3C; // Arbitrary value.
  localparam logic [63:0] HOLES = 64'hFFFF_807F_8071_8000;
  logic        clk_i;
  logic        srst_i;
  wire  [15:0] adr;
  wire         rd_w;
  wire         wr_w;
  wire  [31:0] wdat;
  wire  [3:0]  be;
  wire  [31:0] rdat;
  wire         wt;
  wire  [1:0]  rsp;
  int          err_count;
  int          num_checks;
  int          nbad;
  logic [31:0] q_data[$];
  logic [1:0]  q_rsp[$];
  logic [7:0]  img[16'h8012:16'h8070];
  logic [15:0] a;
  module_identity_capability #(.MIN_WAVELENGTH(16'hCA45),
    .MODULATOR_TECH(4'hA), .WL_CONTROL(1'h1), .MAKER_ORG_ID(ORG),
    .MAKER_SERIAL("SN0001          "), .DATE_CODE("A1B2C3D4"),
    .LOT_CODE("L7"), .EQUIPMENT_ID("EQID012345"),
    .FW_VERSION_MINOR(8'h07)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .address_i(adr), .read_i(rd_w),
    .write_i(wr_w), .writedata_i(wdat), .byteenable_i(be),
    .readdata_o(rdat), .waitrequest_o(wt), .response_o(rsp));
  avalon_host_model i_host (.clk_i(clk_i), .waitrequest_i(wt),
    .address_o(adr), .read_o(rd_w), .write_o(wr_w), .writedata_o(wdat),
    .byteenable_o(be));
  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction
  // Stores a field into the expected image, first byte most significant.
  task automatic put(input int at, input int n, input logic [127:0] v);
    for (int i = 0; i < n; i++) img[at + i] = v[(n - 1 - i) * 8 +: 8];
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e,
                    input logic [1:0] r, input bit k);
    q_data.push_back({24'h000000, e});
    q_rsp.push_back(r);
    i_host.access(1'b0, ad, $urandom, 4'hF, k);
  endtask
  task automatic wr(input logic [15:0] ad, input logic [31:0] d,
                    input logic [3:0] b, input logic [1:0] r, input bit k);
    q_data.push_back(32'h00000000);
    q_rsp.push_back(r);
    i_host.access(1'b1, ad, d, b, k);
  endtask
  // Takes the oldest note at every answer and compares it.
  always @(posedge clk_i) begin
    if (srst_i === 1'b0 && wt === 1'b0 && (rd_w | wr_w) === 1'b1) begin
      check(rdat, q_data.pop_front());
      check({30'h0, rsp}, {30'h0, q_rsp.pop_front()});
    end
  end
  // Watchdog well beyond the fewer than a thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  // Main sequence.
  initial begin
    srst_i = 1'b1;
    void'($urandom(36760));
    put(16'h8012, 6, 48'hCA45_0000_0000);
    put(16'h8018, 3, {8'h0A, 8'h80, 8'h00});
    put(16'h801B, 6, 48'h00_00_00_00_80_80);
    put(16'h8021, 16, "EXAMPLE VENDOR  ");
    put(16'h8031, 3, {rev8(ORG[23:16]), rev8(ORG[15:8]), rev8(ORG[7:0])});
    put(16'h8034, 16, "EXAMPLE PART    ");
    put(16'h8044, 16, "SN0001          ");
    put(16'h8054, 10, {"A1B2C3D4", "L7"});
    put(16'h805E, 10, "EQID012345");
    put(16'h8068, 9, 72'h00_00_00_00_00_07_00_00_00);
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 16'h8012; i <= 16'h8070; i++) begin
      rd(i[15:0], img[i], 2'h0, i != 16'h8070);
    end
    $display("test scan done");
    for (int j = 0; j < 4; j++) begin
      a = HOLES[j * 16 +: 16];
      rd(a, 8'h00, 2'h0, 0);
    end
    $display("test unmapped done");
    for (int i = 0; i < 6; i++) begin
      a = 16'h8012 + 16'($urandom_range(94));
      wr(a, $urandom, 4'($urandom), 2'h0, 1);
      rd(a, img[a], 2'h0, 0);
      nbad++;
    end
    for (int i = 0; i < 256; i++) begin
      wr(16'h8081, $urandom, 4'hF, 2'h0, i != 255);
      nbad++;
    end
    rd(16'h8081, 8'(nbad), 2'h0, 0);
    $display("test refused writes done");
    wr(16'h8080, 32'h00000001, 4'h1, 2'h0, 1);
    rd(16'h8080, 8'h01, 2'h0, 1);
    wr(16'h8014, $urandom, 4'hF, 2'h2, 1);
    rd(16'h8075, 8'h00, 2'h2, 1);
    rd(16'h8014, img[16'h8014], 2'h0, 0);
    nbad++;
    rd(16'h8081, 8'(nbad), 2'h0, 0);
    $display("test error responses done");
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(16'h8080, 8'h00, 2'h0, 1);
    wr(16'h8020, $urandom, 4'hF, 2'h0, 1);
    rd(16'h8020, 8'h80, 2'h0, 1);
    rd(16'h8081, 8'h01, 2'h0, 0);
    $display("test reset done");
    repeat (3) @(posedge clk_i);
    check(32'(q_data.size()), 32'h00000000);
    end_sim();
  end
endmodule // tb_module_identity_capability
`default_nettype wire
